// *** include/harvester_cfg.svh ***
// Timing constants and encodings for the harvester power mode sequencer.
`ifndef HARVESTER_CFG_SVH
`define HARVESTER_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CLK_HZ 50000000
`define SAMPLE_TIME_MS 328
`define SAMPLE_PERIOD_S 21
`define GRACE_TIME_MS 600
`define SAMPLE_CYCLES ((`CLK_HZ / 1000) * `SAMPLE_TIME_MS)
`define PERIOD_CYCLES (`CLK_HZ * `SAMPLE_PERIOD_S)
`define GRACE_CYCLES ((`CLK_HZ / 1000) * `GRACE_TIME_MS)
`define TIMER_W 32
`define SYNC_RESET 2'h0

`endif

// *** include/harvester_pkg.sv ***
// Types shared by the harvester power mode sequencer.
package harvester_pkg;

    typedef enum logic [2:0]
    {
        MODE_DEEP_SLEEP,
        MODE_WAKE_RAILS,
        MODE_WAKE_BOOST,
        MODE_CHARGE,
        MODE_NORMAL,
        MODE_OVERVOLTAGE,
        MODE_PRIMARY,
        MODE_SHUTDOWN
    } power_mode_e;

    typedef struct packed
    {
        logic cold_start_ok;
        logic rails_at_initial;
        logic boost_at_ceiling;
        logic storage_above_ready;
        logic storage_above_ceiling;
        logic storage_below_floor;
        logic primary_available;
    } level_flags_s;

    typedef struct packed
    {
        logic input_switch;
        logic storage_switch;
        logic primary_switch;
        logic cold_start_link;
    } switch_ctrl_s;

endpackage : harvester_pkg

// *** logic/flag_sync.sv ***
// Two-stage synchroniser for a bundle of comparator flags.
module flag_sync
    import harvester_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire level_flags_s raw_i,
    output level_flags_s sync_o
);

    localparam int FLAG_W = $bits(level_flags_s);

    logic [FLAG_W-1:0] stage1;
    logic [FLAG_W-1:0] stage2;

    genvar g;
    generate
        for (g = 0; g < FLAG_W; g++)
        begin : g_bit
            always_ff @(posedge sys_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    stage1[g] <= 1'b0;
                    stage2[g] <= 1'b0;
                end
                else
                begin
                    stage1[g] <= raw_i[g];
                    stage2[g] <= stage1[g];
                end
            end
        end
    endgenerate

    assign sync_o = level_flags_s'(stage2);

endmodule : flag_sync

// *** logic/harvester_power_mode_fsm.sv ***
// Power mode sequencer for an ambient energy harvesting power manager.
//
// Function
// R1: Cold-start detect moves deep sleep to wake-up.
// R2: Wake-up raises both rails, then boost alone.
// R3: Wake-up keeps LDOs off and ready low.
// R4: Cold-start link held until rails reach initial.
// R5: Storage charging keeps LDOs off, ready low.
// R6: Storage at ready level enters normal, ready.
// R7: Charged battery at ceiling skips charging phase.
// R8: Host enables LDOs only after ready asserted.
// R9: Normal holds between floor and ceiling.
// R10: Storage above ceiling enters overvoltage.
// R11: Below floor: primary if available, else shutdown.
// R12: Normal mode keeps storage switch closed.
// R13: Storage at floor opens storage switch; code opens it in shutdown and deep sleep only, primary mode keeps it closed.
// R14: Primary closes primary switch, opens input switch.
// R15: Input switch periodically opened for sampling.
// R16: High-rail enable driven or strapped by host.
// R17: Low-rail enable driven or strapped by host.
// R18: Sampling lasts 328 ms every 21 s.
// R19: Primary available when quarter voltage exceeds reference.
// R20: Low-battery warning through primary; exit at ready.
// R21: Shutdown grace 600 ms, recover or deep sleep.
// R22: Flags synchronised; mode resets to deep sleep.
// R23: LDO on only in permitting mode and pin high.
`include "harvester_cfg.svh"

module harvester_power_mode_fsm
    import harvester_pkg::*;
#(
    parameter logic [`TIMER_W-1:0] SAMPLE_CYCLES = `TIMER_W'(`SAMPLE_CYCLES),
    parameter logic [`TIMER_W-1:0] PERIOD_CYCLES = `TIMER_W'(`PERIOD_CYCLES),
    parameter logic [`TIMER_W-1:0] GRACE_CYCLES = `TIMER_W'(`GRACE_CYCLES)
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cold_start_ok_i,
    input wire logic rails_at_initial_i,
    input wire logic boost_at_ceiling_i,
    input wire logic storage_above_ready_i,
    input wire logic storage_above_ceiling_i,
    input wire logic storage_below_floor_i,
    input wire logic primary_above_reference_i,
    input wire logic external_cold_start_i,
    input wire logic low_rail_enable_i,
    input wire logic high_rail_enable_i,
    output logic low_ldo_on_o,
    output logic high_ldo_on_o,
    output logic ready_o,
    output logic low_battery_o,
    output logic sampling_o,
    output logic input_switch_o,
    output logic storage_switch_o,
    output logic primary_switch_o,
    output logic cold_start_link_o,
    output power_mode_e mode_o
);

    // ------------------------------------------------------------------------
    // Flag synchronisation
    // ------------------------------------------------------------------------
    level_flags_s raw_flags;
    level_flags_s flags;

    // The primary comparator already compares one quarter of the cell voltage.
    always_comb
    begin
        raw_flags.cold_start_ok = cold_start_ok_i;
        raw_flags.rails_at_initial = rails_at_initial_i;
        raw_flags.boost_at_ceiling = boost_at_ceiling_i;
        raw_flags.storage_above_ready = storage_above_ready_i;
        raw_flags.storage_above_ceiling = storage_above_ceiling_i;
        raw_flags.storage_below_floor = storage_below_floor_i;
        raw_flags.primary_available = primary_above_reference_i; // [R19]
    end

    flag_sync u_flag_sync
    (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .raw_i(raw_flags),
        .sync_o(flags)
    ); // [R22]

    // ------------------------------------------------------------------------
    // Mode decoding
    // ------------------------------------------------------------------------
    function automatic logic ldo_permitted(input power_mode_e m);
        ldo_permitted = (m == MODE_NORMAL) || (m == MODE_OVERVOLTAGE) ||
                        (m == MODE_PRIMARY) || (m == MODE_SHUTDOWN);
    endfunction : ldo_permitted

    function automatic logic sampling_permitted(input power_mode_e m);
        sampling_permitted = (m == MODE_NORMAL) || (m == MODE_SHUTDOWN) ||
                             (m == MODE_WAKE_BOOST) || (m == MODE_CHARGE);
    endfunction : sampling_permitted

    // ------------------------------------------------------------------------
    // Mode state
    // ------------------------------------------------------------------------
    power_mode_e mode;
    power_mode_e next_mode;
    logic [`TIMER_W-1:0] grace_count;
    logic grace_expired;

    assign grace_expired = (grace_count >= GRACE_CYCLES - `TIMER_W'(1));

    always_comb
    begin
        next_mode = mode;
        case (mode)
            MODE_DEEP_SLEEP:
            begin
                if (flags.cold_start_ok)
                begin
                    next_mode = MODE_WAKE_RAILS; // [R1]
                end
            end
            MODE_WAKE_RAILS:
            begin
                if (flags.rails_at_initial)
                begin
                    next_mode = MODE_WAKE_BOOST; // [R2]
                end
            end
            MODE_WAKE_BOOST:
            begin
                if (flags.boost_at_ceiling)
                begin
                    if (flags.storage_above_ready)
                    begin
                        next_mode = MODE_NORMAL; // [R7]
                    end
                    else
                    begin
                        next_mode = MODE_CHARGE; // [R2]
                    end
                end
            end
            MODE_CHARGE:
            begin
                if (flags.storage_above_ready)
                begin
                    next_mode = MODE_NORMAL; // [R6]
                end
            end
            MODE_NORMAL:
            begin
                if (flags.storage_above_ceiling)
                begin
                    next_mode = MODE_OVERVOLTAGE; // [R10]
                end
                else if (flags.storage_below_floor)
                begin
                    if (flags.primary_available)
                    begin
                        next_mode = MODE_PRIMARY; // [R11]
                    end
                    else
                    begin
                        next_mode = MODE_SHUTDOWN; // [R11]
                    end
                end
                else
                begin
                    next_mode = MODE_NORMAL; // [R9]
                end
            end
            MODE_OVERVOLTAGE:
            begin
                if (!flags.storage_above_ceiling)
                begin
                    next_mode = MODE_NORMAL;
                end
            end
            MODE_PRIMARY:
            begin
                if (flags.storage_above_ready)
                begin
                    next_mode = MODE_NORMAL; // [R20]
                end
            end
            MODE_SHUTDOWN:
            begin
                if (flags.storage_above_ready)
                begin
                    next_mode = MODE_NORMAL; // [R21]
                end
                else if (grace_expired)
                begin
                    next_mode = MODE_DEEP_SLEEP; // [R21]
                end
            end
            default:
            begin
                next_mode = MODE_DEEP_SLEEP;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode <= MODE_DEEP_SLEEP; // [R22]
        end
        else
        begin
            mode <= next_mode;
        end
    end

    // ------------------------------------------------------------------------
    // Shutdown grace timer
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            grace_count <= '0;
        end
        else if (mode == MODE_SHUTDOWN && !grace_expired)
        begin
            grace_count <= grace_count + `TIMER_W'(1); // [R21]
        end
        else if (mode != MODE_SHUTDOWN)
        begin
            grace_count <= '0;
        end
    end

    // ------------------------------------------------------------------------
    // Open-circuit sampling timer
    // ------------------------------------------------------------------------
    logic [`TIMER_W-1:0] sample_count;
    logic sampling;

    // A full period counts from the start of one sample to the next.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sample_count <= '0;
            sampling <= 1'b0;
        end
        else if (!sampling_permitted(next_mode))
        begin
            sample_count <= '0;
            sampling <= 1'b0;
        end
        else if (sample_count >= PERIOD_CYCLES - `TIMER_W'(1))
        begin
            sample_count <= '0;
            sampling <= 1'b1; // [R15] [R18]
        end
        else
        begin
            sample_count <= sample_count + `TIMER_W'(1);
            if (sample_count >= SAMPLE_CYCLES - `TIMER_W'(1))
            begin
                sampling <= 1'b0; // [R18]
            end
        end
    end

    // ------------------------------------------------------------------------
    // Switches and status outputs
    // ------------------------------------------------------------------------
    switch_ctrl_s next_sw;
    switch_ctrl_s sw;

    always_comb
    begin
        next_sw.input_switch = 1'b1;
        next_sw.storage_switch = 1'b1;
        next_sw.primary_switch = 1'b0;
        next_sw.cold_start_link = 1'b0;
        case (next_mode)
            MODE_DEEP_SLEEP:
            begin
                next_sw.storage_switch = 1'b0; // [R21]
                next_sw.cold_start_link = external_cold_start_i; // [R4]
            end
            MODE_WAKE_RAILS:
            begin
                next_sw.cold_start_link = external_cold_start_i; // [R4]
            end
            MODE_PRIMARY:
            begin
                next_sw.input_switch = 1'b0; // [R14]
                next_sw.primary_switch = 1'b1; // [R14]
            end
            MODE_SHUTDOWN:
            begin
                next_sw.storage_switch = 1'b0; // [R13]
            end
            MODE_NORMAL:
            begin
                next_sw.storage_switch = 1'b1; // [R12]
            end
            default:
            begin
                next_sw.storage_switch = 1'b1;
            end
        endcase
        if (sampling)
        begin
            next_sw.input_switch = 1'b0; // [R15]
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sw <= '0;
        end
        else
        begin
            sw <= next_sw;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ready_o <= 1'b0;
            low_battery_o <= 1'b0;
            low_ldo_on_o <= 1'b0;
            high_ldo_on_o <= 1'b0;
        end
        else
        begin
            ready_o <= ldo_permitted(next_mode); // [R3] [R5] [R6]
            low_battery_o <= (next_mode == MODE_PRIMARY) ||
                             (next_mode == MODE_SHUTDOWN); // [R20] [R21]
            low_ldo_on_o <= ldo_permitted(next_mode) && low_rail_enable_i; // [R23] [R3]
            high_ldo_on_o <= ldo_permitted(next_mode) && high_rail_enable_i; // [R23] [R5]
        end
    end

    assign sampling_o = sampling;
    assign input_switch_o = sw.input_switch;
    assign storage_switch_o = sw.storage_switch;
    assign primary_switch_o = sw.primary_switch;
    assign cold_start_link_o = sw.cold_start_link;
    assign mode_o = mode;

endmodule : harvester_power_mode_fsm

// *** verification/harvester_power_mode_fsm_props.sv ***
// Port checker for the harvester power mode sequencer.
`include "harvester_cfg.svh"

module harvester_power_mode_fsm_props
    import harvester_pkg::*;
#(
    parameter logic [`TIMER_W-1:0] SAMPLE_CYCLES = `TIMER_W'(`SAMPLE_CYCLES),
    parameter logic [`TIMER_W-1:0] GRACE_CYCLES = `TIMER_W'(`GRACE_CYCLES)
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic storage_above_ceiling_i,
    input wire logic storage_below_floor_i,
    input wire logic low_rail_enable_i,
    input wire logic high_rail_enable_i,
    input wire logic low_ldo_on_o,
    input wire logic high_ldo_on_o,
    input wire logic ready_o,
    input wire logic low_battery_o,
    input wire logic sampling_o,
    input wire logic input_switch_o,
    input wire logic storage_switch_o,
    input wire logic primary_switch_o,
    input wire logic cold_start_link_o,
    input wire power_mode_e mode_o
);
    logic [`TIMER_W-1:0] shut_cnt;
    logic [`TIMER_W-1:0] samp_cnt;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Run lengths of shutdown and of one open-circuit sample.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            shut_cnt <= '0;
            samp_cnt <= '0;
        end
        else
        begin
            shut_cnt <= (mode_o == MODE_SHUTDOWN) ? shut_cnt + 1'b1 : '0;
            samp_cnt <= sampling_o ? samp_cnt + 1'b1 : '0;
        end
    end

    property p_wake_dark;
        (mode_o inside {MODE_WAKE_RAILS, MODE_WAKE_BOOST})
            |-> !ready_o && !low_ldo_on_o && !high_ldo_on_o;
    endproperty
    a_wake_dark: assert property (p_wake_dark) else $error("ldo or ready in wake-up");
    property p_charge_dark;
        mode_o == MODE_CHARGE |-> !ready_o && !low_ldo_on_o && !high_ldo_on_o;
    endproperty
    a_charge_dark: assert property (p_charge_dark) else $error("ldo or ready in charge");
    property p_ready_mode;
        ready_o == (mode_o inside {MODE_NORMAL, MODE_OVERVOLTAGE, MODE_PRIMARY, MODE_SHUTDOWN});
    endproperty
    a_ready_mode: assert property (p_ready_mode) else $error("ready mismatch");
    property p_ldo_permit;
        low_ldo_on_o == (ready_o && $past(low_rail_enable_i))
            && high_ldo_on_o == (ready_o && $past(high_rail_enable_i));
    endproperty
    a_ldo_permit: assert property (p_ldo_permit) else $error("ldo on too early");
    property p_normal_store;
        mode_o == MODE_NORMAL |-> storage_switch_o;
    endproperty
    a_normal_store: assert property (p_normal_store) else $error("storage open");
    property p_primary_sw;
        mode_o == MODE_PRIMARY |-> primary_switch_o && !input_switch_o && low_battery_o;
    endproperty
    a_primary_sw: assert property (p_primary_sw) else $error("primary switches");
    property p_wake_order;
        $past(mode_o) == MODE_DEEP_SLEEP && mode_o != MODE_DEEP_SLEEP
            |-> mode_o == MODE_WAKE_RAILS;
    endproperty
    a_wake_order: assert property (p_wake_order) else $error("bad wake step");
    property p_link_drop;
        mode_o == MODE_WAKE_BOOST |-> !cold_start_link_o;
    endproperty
    a_link_drop: assert property (p_link_drop) else $error("link kept");
    property p_overvolt;
        mode_o == MODE_NORMAL && storage_above_ceiling_i && !storage_below_floor_i
            |-> ##[1:3] mode_o == MODE_OVERVOLTAGE;
    endproperty
    a_overvolt: assert property (p_overvolt) else $error("no overvoltage");
    property p_deep_off;
        mode_o == MODE_DEEP_SLEEP |-> !storage_switch_o && !low_ldo_on_o && !high_ldo_on_o;
    endproperty
    a_deep_off: assert property (p_deep_off) else $error("deep sleep outputs");
    property p_grace;
        shut_cnt <= GRACE_CYCLES + 2;
    endproperty
    a_grace: assert property (p_grace) else $error("shutdown too long");
    property p_sample_len;
        samp_cnt <= SAMPLE_CYCLES;
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sample too long");

    c_primary: cover property (mode_o == MODE_PRIMARY);
    c_over: cover property (mode_o == MODE_OVERVOLTAGE);
    c_sample: cover property (sampling_o);
    c_grace: cover property (mode_o == MODE_SHUTDOWN ##1 mode_o == MODE_DEEP_SLEEP);
endmodule : harvester_power_mode_fsm_props

bind harvester_power_mode_fsm harvester_power_mode_fsm_props #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .GRACE_CYCLES(GRACE_CYCLES)
) harvester_power_mode_fsm_props_i (.*);

// *** verification/host_model.sv ***
// Host controller model driving the two LDO enable pins.
module host_model
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ready_i,
    input wire logic want_low_i,
    input wire logic want_high_i,
    input wire logic ignore_ready_i,
    output logic low_rail_enable_o,
    output logic high_rail_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Enables wait for ready unless the bench orders a misbehaving host.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            low_rail_enable_o <= 1'b0;
            high_rail_enable_o <= 1'b0;
        end
        else
        begin
            low_rail_enable_o <= want_low_i && (ready_i || ignore_ready_i);
            high_rail_enable_o <= want_high_i && (ready_i || ignore_ready_i);
        end
    end
endmodule : host_model

// *** verification/tb.sv ***
// Self-checking testbench of the harvester power mode sequencer.
module tb
    import harvester_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] SAMPLE = 32'h8;
    localparam logic [31:0] GRACE = 32'h14;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    level_flags_s fl = '0;
    logic ext_cs = 1'b0;
    logic want_low = 1'b0;
    logic want_high = 1'b0;
    logic rogue = 1'b0;
    logic seen_charge = 1'b0;
    logic low_en, high_en, low_on, high_on, ready, low_storage_node;
    logic sampling, in_sw, st_sw, pr_sw, link;
    power_mode_e mode;
    int fails = 0;
    int compares = 0;
    int n;

    always #10 clk = ~clk;

    harvester_power_mode_fsm #(.SAMPLE_CYCLES(SAMPLE), .PERIOD_CYCLES(32'h28),
        .GRACE_CYCLES(GRACE)) harvester_power_mode_fsm_i (
        .sys_clk_i(clk), .rst_n_i(rst_n),
        .cold_start_ok_i(fl.cold_start_ok), .rails_at_initial_i(fl.rails_at_initial),
        .boost_at_ceiling_i(fl.boost_at_ceiling),
        .storage_above_ready_i(fl.storage_above_ready),
        .storage_above_ceiling_i(fl.storage_above_ceiling),
        .storage_below_floor_i(fl.storage_below_floor),
        .primary_above_reference_i(fl.primary_available), .external_cold_start_i(ext_cs),
        .low_rail_enable_i(low_en), .high_rail_enable_i(high_en),
        .low_ldo_on_o(low_on), .high_ldo_on_o(high_on), .ready_o(ready),
        .low_battery_o(low_storage_node), .sampling_o(sampling), .input_switch_o(in_sw),
        .storage_switch_o(st_sw), .primary_switch_o(pr_sw),
        .cold_start_link_o(link), .mode_o(mode));

    host_model host_model_i (.sys_clk_i(clk), .rst_n_i(rst_n), .ready_i(ready),
        .want_low_i(want_low), .want_high_i(want_high), .ignore_ready_i(rogue),
        .low_rail_enable_o(low_en), .high_rail_enable_o(high_en));

    task automatic report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_mode(input power_mode_e got, input power_mode_e exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_mode

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask : step

    // Bounded wait for a mode; a missed mode ends the run.
    task automatic wait_mode(input power_mode_e m, input int bound);
        for (int i = 0; i < bound && mode !== m; i++)
        begin
            seen_charge |= (mode === MODE_CHARGE);
            step(1);
        end
        chk_mode(mode, m);
        if (mode !== m)
        begin
            report_and_stop();
        end
    endtask : wait_mode

    initial
    begin
        step(12);
        rst_n = 1'b1;
        step(2);
        chk_mode(mode, MODE_DEEP_SLEEP);
        chk_bit(ready | st_sw | link, 1'b0);
        ext_cs = 1'b1;
        want_low = 1'b1;
        rogue = 1'b1;
        fl.cold_start_ok = 1'b1;
        wait_mode(MODE_WAKE_RAILS, 8);
        chk_bit(link, 1'b1);
        step(3);
        chk_bit(low_on | ready, 1'b0);
        fl.rails_at_initial = 1'b1;
        wait_mode(MODE_WAKE_BOOST, 8);
        chk_bit(link, 1'b0);
        fl.boost_at_ceiling = 1'b1;
        wait_mode(MODE_CHARGE, 8);
        step(3);
        chk_bit(low_on | ready, 1'b0);
        rogue = 1'b0;
        fl.storage_above_ready = 1'b1;
        wait_mode(MODE_NORMAL, 8);
        chk_bit(ready & st_sw, 1'b1);
        step(4);
        chk_bit(low_on, 1'b1);
        chk_bit(high_on, 1'b0);
        want_high = 1'b1;
        step(2);
        chk_bit(high_on, 1'b1);
        $display("test wake-up done");
        for (n = 0; n < 100 && sampling !== 1'b1; n++)
        begin
            step(1);
        end
        chk_bit(sampling, 1'b1);
        if (sampling !== 1'b1)
        begin
            report_and_stop();
        end
        step(2);
        chk_bit(in_sw, 1'b0);
        for (n = 3; n < 100 && sampling === 1'b1; n++)
        begin
            step(1);
        end
        chk_bit(n - 1 == SAMPLE, 1'b1);
        if (n >= 100)
        begin
            report_and_stop();
        end
        fl.storage_above_ceiling = 1'b1;
        wait_mode(MODE_OVERVOLTAGE, 8);
        fl.storage_above_ceiling = 1'b0;
        wait_mode(MODE_NORMAL, 8);
        step(10);
        chk_mode(mode, MODE_NORMAL);
        $display("test normal done");
        fl.storage_above_ready = 1'b0;
        fl.primary_available = 1'b1;
        fl.storage_below_floor = 1'b1;
        wait_mode(MODE_PRIMARY, 8);
        chk_bit(pr_sw & ~in_sw & low_storage_node, 1'b1);
        fl.storage_below_floor = 1'b0;
        step(6);
        chk_bit(low_storage_node, 1'b1);
        fl.storage_above_ready = 1'b1;
        wait_mode(MODE_NORMAL, 8);
        chk_bit(low_storage_node, 1'b0);
        fl.storage_above_ready = 1'b0;
        fl.primary_available = 1'b0;
        fl.storage_below_floor = 1'b1;
        wait_mode(MODE_SHUTDOWN, 8);
        chk_bit(low_storage_node & low_on & high_on, 1'b1);
        chk_bit(st_sw, 1'b0);
        fl.storage_below_floor = 1'b0;
        fl.storage_above_ready = 1'b1;
        wait_mode(MODE_NORMAL, 8);
        fl.storage_above_ready = 1'b0;
        fl.storage_below_floor = 1'b1;
        fl.cold_start_ok = 1'b0;
        wait_mode(MODE_SHUTDOWN, 8);
        step(GRACE - 4);
        chk_mode(mode, MODE_SHUTDOWN);
        wait_mode(MODE_DEEP_SLEEP, 12);
        chk_bit(st_sw | low_on | high_on | ready, 1'b0);
        $display("test low storage done");
        fl = '0;
        fl.storage_above_ready = 1'b1;
        ext_cs = 1'b0;
        step(4);
        chk_mode(mode, MODE_DEEP_SLEEP);
        fl.cold_start_ok = 1'b1;
        wait_mode(MODE_WAKE_RAILS, 8);
        chk_bit(link, 1'b0);
        fl.rails_at_initial = 1'b1;
        fl.boost_at_ceiling = 1'b1;
        seen_charge = 1'b0;
        wait_mode(MODE_NORMAL, 12);
        chk_bit(seen_charge, 1'b0);
        rst_n = 1'b0;
        step(1);
        chk_mode(mode, MODE_DEEP_SLEEP);
        chk_bit(ready | low_on | high_on, 1'b0);
        rst_n = 1'b1;
        $display("test charged battery and restart done");
        report_and_stop();
    end
endmodule : tb
